// >>> fcr_core_model.sv
// Behavioural floppy core stand-in driving drive selects and the density level
`timescale 1ns/1ps
module fcr_core_model (
    input wire logic [1:0] drive_req,
    input wire logic via_pp,
    input wire logic dens_lvl,
    output logic drive_select_zero_n,
    output logic drive_select_one_n,
    output logic pp_drive_select_zero_n,
    output logic pp_drive_select_one_n,
    output logic pp_route_sel,
    output logic core_density
);
    // Only the chosen route carries selects; the idle route sits at its pull-up level
    assign drive_select_zero_n = !(drive_req[0] && !via_pp);
    assign drive_select_one_n = !(drive_req[1] && !via_pp);
    assign pp_drive_select_zero_n = !(drive_req[0] && via_pp);
    assign pp_drive_select_one_n = !(drive_req[1] && via_pp);
    assign pp_route_sel = via_pp;
    assign core_density = dens_lvl;
endmodule : fcr_core_model

// >>> fcr_defines.svh
// Offsets, field positions, reset values and bus codes of the floppy configuration bank
`ifndef FCR_DEFINES_SVH
`define FCR_DEFINES_SVH

// ************************************************************
// Register indexes; byte address is four times the index
// ************************************************************
`define FCR_IDX_MODE 8'hF0
`define FCR_IDX_OPTION 8'hF1
`define FCR_IDX_TYPE 8'hF2

// ************************************************************
// Field positions
// ************************************************************
`define FCR_MODE_NOBURST_BIT 1
`define FCR_MODE_COMPAT_LSB 2
`define FCR_MODE_PUSHPULL_BIT 6
`define FCR_OPT_FORCE_WP_BIT 0
`define FCR_OPT_DENSITY_LSB 2
`define FCR_TYPE_DRIVE_A_LSB 0

// ************************************************************
// Reset values and writable masks
// ************************************************************
`define FCR_MODE_RESET 8'h0E
`define FCR_OPTION_RESET 8'h00
`define FCR_TYPE_RESET 8'h00
`define FCR_MODE_MASK 8'h4E
`define FCR_OPTION_MASK 8'h0D
`define FCR_TYPE_MASK 8'h03

// ************************************************************
// AXI response codes
// ************************************************************
`define FCR_RESP_OKAY 2'h0
`define FCR_RESP_SLVERR 2'h2

`endif

// >>> fcr_floppy_config_regs.sv
// Floppy controller configuration register bank with an AXI4-Lite slave port
`timescale 1ns/1ps
`include "fcr_defines.svh"

module fcr_floppy_config_regs
    import fcr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic hard_reset,
    input wire logic standby_power_on_reset,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Floppy core side, same clock
    input wire logic drive_select_zero_n,
    input wire logic drive_select_one_n,
    input wire logic pp_drive_select_zero_n,
    input wire logic pp_drive_select_one_n,
    input wire logic pp_route_sel,
    input wire logic core_density,
    output fcr_cfg_t cfg,
    output logic write_protect_to_core_n,
    output logic status_register_a_wp,
    output logic density_out,
    output logic boot_drive_sel,
    output logic open_drain_buffer_type
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The type register sits at byte 0x3C8, so ten address bits are the least
    generate
        if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
            $error("fcr_floppy_config_regs: ADDR_W must lie between 10 and 32");
        end
    endgenerate

    // ************************************************************
    // Reset synchronisers and configuration reset
    // ************************************************************
    logic hard_meta_reg;
    logic hard_sync_reg;
    logic standby_meta_reg;
    logic standby_sync_reg;
    logic cfg_reset;

    // Both reset pins come from outside the clock domain
    always_ff @(posedge mclk) begin
        if (reset) begin
            hard_meta_reg <= 1'b0;
            hard_sync_reg <= 1'b0;
            standby_meta_reg <= 1'b0;
            standby_sync_reg <= 1'b0;
        end else begin
            hard_meta_reg <= hard_reset;
            hard_sync_reg <= hard_meta_reg;
            standby_meta_reg <= standby_power_on_reset;
            standby_sync_reg <= standby_meta_reg;
        end
    end

    // Any of the three resets puts the fields back at their defaults
    assign cfg_reset = reset | hard_sync_reg | standby_sync_reg;

    // ************************************************************
    // Address decode
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_MODE = ADDR_W'({`FCR_IDX_MODE, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_OPTION = ADDR_W'({`FCR_IDX_OPTION, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_TYPE = ADDR_W'({`FCR_IDX_TYPE, 2'b00});

    logic [ADDR_W-1:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic do_write;
    logic wr_hit_mode;
    logic wr_hit_option;
    logic wr_hit_type;
    logic wr_hit;

    // Low address bits are ignored so any byte of a word reaches that word
    assign wr_hit_mode = aw_addr_reg[ADDR_W-1:2] == ADDR_MODE[ADDR_W-1:2];
    assign wr_hit_option = aw_addr_reg[ADDR_W-1:2] == ADDR_OPTION[ADDR_W-1:2];
    assign wr_hit_type = aw_addr_reg[ADDR_W-1:2] == ADDR_TYPE[ADDR_W-1:2];
    assign wr_hit = wr_hit_mode | wr_hit_option | wr_hit_type;

    // ************************************************************
    // Write channel
    // ************************************************************
    // Address and data are caught independently, then committed together
    assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;

    // Write address holding stage
    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    // Write address ready, withheld while a response is pending
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
        end else if (!aw_full_reg && !s_axi_bvalid && !do_write) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data holding stage; only the low byte carries register bits
    always_ff @(posedge mclk) begin
        if (reset) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    // Write data ready
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
        end else if (!w_full_reg && !s_axi_bvalid && !do_write) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response one cycle after both halves are present
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FCR_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `FCR_RESP_OKAY : `FCR_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [7:0] mode_reg;
    logic [7:0] option_reg;
    logic [7:0] type_reg;
    logic cfg_we;

    // A word write without lane 0 changes nothing in these byte-wide registers
    assign cfg_we = do_write & w_lane0_reg;

    // Mode: burst control, compatibility mode, driver type
    always_ff @(posedge mclk) begin
        if (cfg_reset) begin
            mode_reg <= `FCR_MODE_RESET;
        end else if (cfg_we && wr_hit_mode) begin
            mode_reg <= w_data_reg & `FCR_MODE_MASK;
        end
    end

    // Option: forced write protect and density select
    always_ff @(posedge mclk) begin
        if (cfg_reset) begin
            option_reg <= `FCR_OPTION_RESET;
        end else if (cfg_we && wr_hit_option) begin
            option_reg <= w_data_reg & `FCR_OPTION_MASK;
        end
    end

    // Drive type store, read back as written
    always_ff @(posedge mclk) begin
        if (cfg_reset) begin
            type_reg <= `FCR_TYPE_RESET;
        end else if (cfg_we && wr_hit_type) begin
            type_reg <= w_data_reg & `FCR_TYPE_MASK;
        end
    end

    // ************************************************************
    // Read channel
    // ************************************************************
    logic [7:0] rd_byte;
    logic rd_hit;

    // Reserved bits were masked on the way in, so they read zero
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        if (s_axi_araddr[ADDR_W-1:2] == ADDR_MODE[ADDR_W-1:2]) begin
            rd_byte = mode_reg;
        end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_OPTION[ADDR_W-1:2]) begin
            rd_byte = option_reg;
        end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_TYPE[ADDR_W-1:2]) begin
            rd_byte = type_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read address ready, dropped while the data beat waits
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Read data captured at the address handshake, so it is a snapshot
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FCR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? `FCR_RESP_OKAY : `FCR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Floppy core outputs
    // ************************************************************
    logic sel_zero;
    logic sel_one;
    logic wp_forced;
    logic density_next;

    // The parallel-port route supplies its own drive selects
    assign sel_zero = pp_route_sel ? ~pp_drive_select_zero_n : ~drive_select_zero_n;
    assign sel_one = pp_route_sel ? ~pp_drive_select_one_n : ~drive_select_one_n;

    // Force applies only while some drive is selected
    assign wp_forced = (sel_zero & option_reg[`FCR_OPT_FORCE_WP_BIT])
        | (sel_one & option_reg[`FCR_OPT_FORCE_WP_BIT]);

    // Density override; the two normal codes pass the core's value
    always_comb begin
        unique case (fcr_density_t'(option_reg[`FCR_OPT_DENSITY_LSB +: 2]))
            FCR_DENS_NORMAL: density_next = core_density;
            FCR_DENS_USER: density_next = core_density;
            FCR_DENS_FORCE_ONE: density_next = 1'b1;
            FCR_DENS_FORCE_ZERO: density_next = 1'b0;
        endcase
    end

    // Write protect to the core is active low, status bit is active high
    always_ff @(posedge mclk) begin
        if (cfg_reset) begin
            write_protect_to_core_n <= 1'b1;
            status_register_a_wp <= 1'b0;
        end else begin
            write_protect_to_core_n <= ~wp_forced;
            status_register_a_wp <= wp_forced;
        end
    end

    // Density pin follows the override one cycle late; while a hard or standby reset holds the fields
    // the default normal code is in force, so the core's level passes; reset itself drives the pin low
    always_ff @(posedge mclk) begin
        if (reset) begin
            density_out <= 1'b0;
        end else if (cfg_reset) begin
            density_out <= core_density;
        end else begin
            density_out <= density_next;
        end
    end

    // Boot drive is fixed; no field can move it
    always_ff @(posedge mclk) begin
        if (reset) begin
            boot_drive_sel <= 1'b0;
        end else begin
            boot_drive_sel <= 1'b0;
        end
    end

    // Pad driver type: high means open drain, the safe default
    always_ff @(posedge mclk) begin
        if (cfg_reset) begin
            open_drain_buffer_type <= 1'b1;
        end else begin
            open_drain_buffer_type <= ~mode_reg[`FCR_MODE_PUSHPULL_BIT];
        end
    end

    // Configuration bundle for the core, registered once more
    always_ff @(posedge mclk) begin
        if (cfg_reset) begin
            cfg <= '{non_burst: 1'b1, compat_mode: FCR_COMPAT_FIRST, push_pull: 1'b0,
                     force_wp: 1'b0, density_sel: FCR_DENS_NORMAL, drive_a_type: 2'h0};
        end else begin
            cfg.non_burst <= mode_reg[`FCR_MODE_NOBURST_BIT];
            cfg.compat_mode <= fcr_compat_t'(mode_reg[`FCR_MODE_COMPAT_LSB +: 2]);
            cfg.push_pull <= mode_reg[`FCR_MODE_PUSHPULL_BIT];
            cfg.force_wp <= option_reg[`FCR_OPT_FORCE_WP_BIT];
            cfg.density_sel <= fcr_density_t'(option_reg[`FCR_OPT_DENSITY_LSB +: 2]);
            cfg.drive_a_type <= type_reg[`FCR_TYPE_DRIVE_A_LSB +: 2];
        end
    end

endmodule : fcr_floppy_config_regs

// >>> fcr_floppy_config_regs_checker.sv
// Concurrent assertions for the floppy configuration bank, bound to its top module
`timescale 1ns/1ps
`include "fcr_defines.svh"
module fcr_floppy_config_regs_checker
    import fcr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic drive_select_zero_n,
    input wire logic drive_select_one_n,
    input wire logic pp_drive_select_zero_n,
    input wire logic pp_drive_select_one_n,
    input wire logic pp_route_sel,
    input wire logic core_density,
    input wire fcr_cfg_t cfg,
    input wire logic write_protect_to_core_n,
    input wire logic status_register_a_wp,
    input wire logic density_out,
    input wire logic boot_drive_sel,
    input wire logic open_drain_buffer_type
);
    // Either drive selected on whichever route is active
    wire sel_any = pp_route_sel ? !(pp_drive_select_zero_n && pp_drive_select_one_n)
                                : !(drive_select_zero_n && drive_select_one_n);

    localparam logic [ADDR_W-3:0] IDX_MODE = (ADDR_W-2)'(`FCR_IDX_MODE);
    localparam logic [ADDR_W-3:0] IDX_OPTION = (ADDR_W-2)'(`FCR_IDX_OPTION);
    localparam logic [ADDR_W-3:0] IDX_TYPE = (ADDR_W-2)'(`FCR_IDX_TYPE);
    logic [ADDR_W-1:0] rd_addr_reg;
    logic [7:0] rsvd_mask;

    // Address of the read being answered, caught at its handshake
    always_ff @(posedge mclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_reg <= s_axi_araddr;
        end
    end

    // Bits that must read zero for that word; an unmapped word reads all zero
    always_comb begin
        rsvd_mask = 8'hFF;
        if (rd_addr_reg[ADDR_W-1:2] == IDX_MODE) begin
            rsvd_mask = ~`FCR_MODE_MASK;
        end else if (rd_addr_reg[ADDR_W-1:2] == IDX_OPTION) begin
            rsvd_mask = ~`FCR_OPTION_MASK;
        end else if (rd_addr_reg[ADDR_W-1:2] == IDX_TYPE) begin
            rsvd_mask = ~`FCR_TYPE_MASK;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // Outputs lag the register by one edge, so compare against cfg and last cycle's inputs
    chk_force_write_protect: assert property (!$past(reset) |->
        write_protect_to_core_n == !(cfg.force_wp && $past(sel_any))) else $error("write protect mismatch");
    chk_status_wp_mirror: assert property (status_register_a_wp == !write_protect_to_core_n)
        else $error("status write protect differs");
    chk_density_override: assert property (!$past(reset) |-> density_out ==
        (cfg.density_sel == FCR_DENS_FORCE_ONE ? 1'b1 :
         cfg.density_sel == FCR_DENS_FORCE_ZERO ? 1'b0 : $past(core_density))) else $error("density mismatch");
    chk_driver_type: assert property (open_drain_buffer_type == !cfg.push_pull)
        else $error("driver type mismatch");
    chk_boot_drive_zero: assert property (boot_drive_sel == 1'b0)
        else $error("boot drive not zero");
    chk_reset_defaults: assert property ($past(reset) |-> cfg.non_burst && cfg.compat_mode == FCR_COMPAT_FIRST
        && !cfg.push_pull && !cfg.force_wp && cfg.density_sel == FCR_DENS_NORMAL && cfg.drive_a_type == 2'h0)
        else $error("defaults wrong after reset");
    chk_reserved_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000
        && (s_axi_rdata[7:0] & rsvd_mask) == 8'h00) else $error("reserved bits read nonzero");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule : fcr_floppy_config_regs_checker

bind fcr_floppy_config_regs fcr_floppy_config_regs_checker #(.ADDR_W(ADDR_W)) chk_u (.mclk, .reset, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .drive_select_zero_n,
    .drive_select_one_n, .pp_drive_select_zero_n, .pp_drive_select_one_n, .pp_route_sel, .core_density, .cfg,
    .write_protect_to_core_n, .status_register_a_wp, .density_out, .boot_drive_sel, .open_drain_buffer_type);

// >>> fcr_floppy_config_regs_tb.sv
// Self-checking testbench for the floppy configuration bank
`timescale 1ns/1ps
`include "fcr_defines.svh"
module fcr_floppy_config_regs_tb
    import fcr_pkg::*;
();
    localparam logic [11:0] A_MODE = {2'h0, `FCR_IDX_MODE, 2'h0};
    localparam logic [11:0] A_OPT = {2'h0, `FCR_IDX_OPTION, 2'h0};
    localparam logic [11:0] A_TYPE = {2'h0, `FCR_IDX_TYPE, 2'h0};
    logic mclk, reset, hard_reset, standby_power_on_reset;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, drive_req;
    logic via_pp, dens_lvl, drive_select_zero_n, drive_select_one_n, pp_drive_select_zero_n;
    logic pp_drive_select_one_n, pp_route_sel, core_density;
    fcr_cfg_t cfg;
    logic write_protect_to_core_n, status_register_a_wp, density_out, boot_drive_sel, open_drain_buffer_type;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    fcr_floppy_config_regs dut_u (.mclk, .reset, .hard_reset, .standby_power_on_reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .drive_select_zero_n, .drive_select_one_n, .pp_drive_select_zero_n, .pp_drive_select_one_n,
        .pp_route_sel, .core_density, .cfg, .write_protect_to_core_n, .status_register_a_wp, .density_out,
        .boot_drive_sel, .open_drain_buffer_type);
    fcr_core_model core_u (.drive_req, .via_pp, .dens_lvl, .drive_select_zero_n, .drive_select_one_n,
        .pp_drive_select_zero_n, .pp_drive_select_one_n, .pp_route_sel, .core_density);

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // Write: address and data offered together, each dropped once taken, then wait for the response
    task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [3:0] stb);
        logic aw_open;
        logic w_open;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_wstrb <= stb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_open = 1'b1;
        w_open = 1'b1;
        while (aw_open || w_open) begin
            @(posedge mclk);
            if (aw_open && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_open = 1'b0;
            end
            if (w_open && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_open = 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge mclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge mclk);
        while (s_axi_arready !== 1'b1) @(posedge mclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge mclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, d, e);
        chk("rresp", r, `FCR_RESP_OKAY);
    endtask : rc

    // Register commit, cfg and core outputs each take an edge, so allow a margin
    task automatic settle;
        repeat (4) @(posedge mclk);
    endtask : settle

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_defaults;
        rc(A_MODE, 32'h0000000E, "mode_reset");
        rc(A_OPT, 32'h0, "option_reset");
        rc(A_TYPE, 32'h0, "type_reset");
        chk("open_drain", open_drain_buffer_type, 1'b1);
        chk("boot", boot_drive_sel, 1'b0);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_mode;
        wr(A_MODE, 32'hFFFFFFDF, 4'hF);
        rc(A_MODE, 32'h0000004E, "mode_reserved");
        settle();
        chk("push_pull", open_drain_buffer_type, 1'b0);
        for (int m = 0; m < 4; m++) begin
            wr(A_MODE, 32'(m << 2), 4'hF);
            settle();
            chk("compat", cfg.compat_mode, m);
            chk("burst", cfg.non_burst, 1'b0);
            chk("open_drain", open_drain_buffer_type, 1'b1);
            chk("boot", boot_drive_sel, 1'b0);
        end
        $display("test mode done");
    endtask : t_mode

    task automatic t_wp;
        for (int f = 0; f < 2; f++) begin
            wr(A_OPT, 32'(f), 4'hF);
            for (int k = 0; k < 8; k++) begin
                drive_req <= k[1:0];
                via_pp <= k[2];
                settle();
                chk("wp_n", write_protect_to_core_n, !(f == 1 && k[1:0] != 2'h0));
                chk("sra_wp", status_register_a_wp, f == 1 && k[1:0] != 2'h0);
            end
        end
        drive_req <= 2'h0;
        $display("test write protect done");
    endtask : t_wp

    task automatic t_dens;
        for (int m = 0; m < 4; m++) begin
            wr(A_OPT, 32'(m << 2), 4'hF);
            for (int c = 0; c < 2; c++) begin
                dens_lvl <= c[0];
                settle();
                chk("density", density_out, m == 2 ? 1 : m == 3 ? 0 : c);
                chk("density_sel", cfg.density_sel, m);
            end
        end
        $display("test density done");
    endtask : t_dens

    task automatic t_type;
        wr(A_TYPE, 32'hFFFFFFFF, 4'hF);
        rc(A_TYPE, 32'h00000003, "type_rw");
        wr(A_TYPE, 32'h00000002, 4'h0);
        rc(A_TYPE, 32'h00000003, "type_no_strobe");
        chk("drive_a", cfg.drive_a_type, 2'h3);
        wr(12'h000, 32'h00000001, 4'hF);
        chk("unmapped_bresp", r, `FCR_RESP_SLVERR);
        rd(12'h000);
        chk("unmapped_rdata", d, 32'h0);
        chk("unmapped_rresp", r, `FCR_RESP_SLVERR);
        $display("test type done");
    endtask : t_type

    task automatic t_hard;
        for (int p = 0; p < 2; p++) begin
            wr(A_MODE, 32'h00000040, 4'hF);
            wr(A_OPT, 32'h0000000D, 4'hF);
            wr(A_TYPE, 32'h00000001, 4'hF);
            hard_reset <= (p == 0);
            standby_power_on_reset <= (p == 1);
            repeat (3) @(posedge mclk);
            hard_reset <= 1'b0;
            standby_power_on_reset <= 1'b0;
            repeat (6) @(posedge mclk);
            rc(A_MODE, 32'h0000000E, "mode_por");
            rc(A_OPT, 32'h0, "option_por");
            rc(A_TYPE, 32'h0, "type_por");
            chk("non_burst_por", cfg.non_burst, 1'b1);
            chk("open_drain_por", open_drain_buffer_type, 1'b1);
            chk("density_por", density_out, dens_lvl);
        end
        $display("test hard reset done");
    endtask : t_hard

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        reset = 1'b1;
        {hard_reset, standby_power_on_reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, via_pp, dens_lvl, drive_req} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_defaults();
        t_mode();
        t_wp();
        t_dens();
        t_type();
        t_hard();
        results();
    end
endmodule : fcr_floppy_config_regs_tb

// >>> fcr_pkg.sv
// Types shared by the floppy configuration bank
package fcr_pkg;

    // Compatibility modes of the floppy register set
    typedef enum logic [1:0] {
        FCR_COMPAT_THIRD = 2'h0,
        FCR_COMPAT_SECOND = 2'h1,
        FCR_COMPAT_RSVD = 2'h2,
        FCR_COMPAT_FIRST = 2'h3
    } fcr_compat_t;

    // Density select overrides
    typedef enum logic [1:0] {
        FCR_DENS_NORMAL = 2'h0,
        FCR_DENS_USER = 2'h1,
        FCR_DENS_FORCE_ONE = 2'h2,
        FCR_DENS_FORCE_ZERO = 2'h3
    } fcr_density_t;

    // Configuration handed to the floppy core and pad ring
    typedef struct packed {
        logic non_burst;
        fcr_compat_t compat_mode;
        logic push_pull;
        logic force_wp;
        fcr_density_t density_sel;
        logic [1:0] drive_a_type;
    } fcr_cfg_t;

endpackage : fcr_pkg
